// ===== common/hpse_regs.svh
// Purpose: Named offsets, field positions, reset values and timing for the slot block.
// Assumes: One logical slot register, 32 bits wide, on a byte-addressed plain port.
// Notes: Definitions only; the package holds the types.
`ifndef HPSE_REGS_SVH
`define HPSE_REGS_SVH

// Register map.
`define HPSE_ADDR_W 8
`define HPSE_SLOT_OFS 8'h00

// Field positions inside the slot register.
`define HPSE_EV_LSB 16
`define HPSE_EV_MSB 20
`define HPSE_MSK_LSB 24
`define HPSE_MSK_MSB 30
`define HPSE_EV_CPF 4
`define HPSE_EV_LAT 3
`define HPSE_EV_BTN 2
`define HPSE_EV_IPF 1
`define HPSE_EV_PRS 0
`define HPSE_IMSK_MSB 4
`define HPSE_SMSK_LSB 5
`define HPSE_SMSK_MSB 6

// Field positions inside the status half-word.
`define HPSE_ST_CAP_MSB 13
`define HPSE_ST_CAP_LSB 12
`define HPSE_ST_PRS_MSB 11
`define HPSE_ST_PRS_LSB 10
`define HPSE_ST_M66 9
`define HPSE_ST_LAT 8
`define HPSE_ST_BTN 7
`define HPSE_ST_FLT 6
`define HPSE_ST_ATT_MSB 5
`define HPSE_ST_ATT_LSB 4
`define HPSE_ST_PWR_MSB 3
`define HPSE_ST_PWR_LSB 2
`define HPSE_ST_SS_MSB 1
`define HPSE_ST_SS_LSB 0

// Reserved fields, which always read zero.
`define HPSE_RSV_ST_MSB 15
`define HPSE_RSV_ST_LSB 14
`define HPSE_RSV_EV_MSB 23
`define HPSE_RSV_EV_LSB 21
`define HPSE_RSV_TOP 31

// Debounce vector layout: presence pair, latch sensor, button.
`define HPSE_DB_BTN 0
`define HPSE_DB_LAT 1
`define HPSE_DB_PRS_LSB 2
`define HPSE_DB_PRS_MSB 3
`define HPSE_DB_W 4

// Reset values.
`define HPSE_EV_RST 5'h00
`define HPSE_MSK_RST 7'h7F
`define HPSE_DB_RST 4'hC
`define HPSE_WORD_RST 32'h0000_0000
`define HPSE_CAP_EMPTY 2'h0

// Timing: clock period and least settle time of a debounced input.
`define HPSE_CLK_NS 5
`define HPSE_DEB_NS 1000
`define HPSE_DEB_CYC ((`HPSE_DEB_NS + `HPSE_CLK_NS - 1) / `HPSE_CLK_NS)
`define HPSE_CNT_W 8

`endif

// ===== common/hpse_pkg.sv
// Purpose: Types shared by the slot status and event logic.
// Assumes: Codes as reported in the slot status field.
// Notes: Nothing is imported; users write hpse_pkg::name.
package hpse_pkg;

   // Slot state code.
   typedef enum logic [1:0] {
      HPSE_SS_RSVD = 2'b00,
      HPSE_SS_POWERED = 2'b01,
      HPSE_SS_ENABLED = 2'b10,
      HPSE_SS_DISABLED = 2'b11
   } hpse_slot_state_t;

   // Indicator code, shared by the power and attention indicators.
   typedef enum logic [1:0] {
      HPSE_IND_RSVD = 2'b00,
      HPSE_IND_ON = 2'b01,
      HPSE_IND_BLINK = 2'b10,
      HPSE_IND_OFF = 2'b11
   } hpse_ind_t;

   // Presence pair code.
   typedef enum logic [1:0] {
      HPSE_PRS_7W5 = 2'b00,
      HPSE_PRS_25W = 2'b01,
      HPSE_PRS_15W = 2'b10,
      HPSE_PRS_EMPTY = 2'b11
   } hpse_prs_t;

   // Debounce vector and event vector.
   typedef logic [3:0] hpse_db_vec_t;
   typedef logic [4:0] hpse_ev_vec_t;

endpackage

// ===== common/hpse_db_if.sv
// Purpose: Carries raw slot sensor levels to the debouncer and settled levels back.
// Assumes: Single clock domain.
// Notes: Vector layout follows the debounce positions in the register header.
`timescale 1ns/1ps
interface hpse_db_if;
   hpse_pkg::hpse_db_vec_t raw;
   hpse_pkg::hpse_db_vec_t clean;
   modport user (output raw, input clean);
   modport filt (input raw, output clean);
endinterface

// ===== design/hpse_debounce.sv
// Purpose: Synchronises and debounces the button, latch sensor and presence inputs.
// Assumes: Raw inputs may bounce; a level counts once it holds for the settle time.
// Notes: The first sync stage feeds only the second.
`timescale 1ns/1ps
`include "hpse_regs.svh"
module hpse_debounce (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Sensor levels.
   hpse_db_if.filt db
);

   hpse_pkg::hpse_db_vec_t sy1_q;
   hpse_pkg::hpse_db_vec_t sy2_q;
   hpse_pkg::hpse_db_vec_t clean_q;
   logic [`HPSE_CNT_W-1:0] cnt_q [`HPSE_DB_W];

   // Two-stage synchroniser.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sy1_q <= `HPSE_DB_RST;
         sy2_q <= `HPSE_DB_RST;
      end else begin
         sy1_q <= db.raw;
         sy2_q <= sy1_q;
      end
   end

   // A bit follows its input only after the input held steady for the settle time.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         clean_q <= `HPSE_DB_RST;
         for (int i = 0; i < `HPSE_DB_W; i++) begin
            cnt_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < `HPSE_DB_W; i++) begin
            if (sy2_q[i] == clean_q[i]) begin
               cnt_q[i] <= '0;
            end else if (cnt_q[i] == `HPSE_CNT_W'(`HPSE_DEB_CYC - 1)) begin
               clean_q[i] <= sy2_q[i]; // R17
               cnt_q[i] <= '0;
            end else begin
               cnt_q[i] <= cnt_q[i] + `HPSE_CNT_W'(1);
            end
         end
      end
   end

   assign db.clean = clean_q;

endmodule

// ===== design/hpse_slot.sv
// Purpose: Status, event latch and mask logic of one hot-plug slot register.
// Assumes: Sensor and power controller inputs are synchronous to clk_i.
// Notes: Events are sticky and write-one-to-clear; a new event beats a clear.
`timescale 1ns/1ps
`include "hpse_regs.svh"
// Contract
// R1: Bits 13:12 report card bus capability, valid while the slot is occupied.
// R2: Bits 11:10 show the debounced presence pin pair, always valid.
// R3: Bit 9 captures 66 MHz capability when the slot powers up or enables.
// R4: Bit 8 shows the debounced latch sensor, one when open.
// R5: Bit 7 shows the debounced attention button, one while pressed.
// R6: Bit 6 mirrors the power controller fault latch.
// R7: Bits 5:4 report the attention indicator state, read only.
// R8: Attention indicator uses the power indicator encoding.
// R9: Bits 3:2 report the power indicator state.
// R10: Bits 1:0 report the slot state.
// R11: Event bit 20 sets on a connected power fault.
// R12: Event bit 19 sets on any latch sensor status change.
// R13: Event bit 18 sets only when the button status rises.
// R14: Event bit 17 sets on an isolated power fault.
// R15: Event bit 16 sets when either presence status bit changes.
// R16: Events reset to zero, hold, clear on writing one; reserved bits read zero.
// R17: Button, latch and presence inputs are synchronised and debounced first.
// R18: Error pending rises for an unmasked latched error event, drops when cleared.
// R19: Masks gate only interrupt and error outputs, never event latching.
module hpse_slot (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port.
   input wire logic [`HPSE_ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Slot sensors.
   input wire logic attention_button_i,
   input wire logic retention_latch_sensor_i,
   input wire logic presence_pin_one_n_i,
   input wire logic presence_pin_two_n_i,
   input wire logic [1:0] card_bus_capability_i,
   input wire logic card_66mhz_capable_i,
   // Power controller.
   input wire logic power_fault_state_i,
   input wire logic connected_power_fault_i,
   input wire logic isolated_power_fault_i,
   input wire logic [1:0] attention_indicator_state_i,
   input wire logic [1:0] power_indicator_state_i,
   input wire logic [1:0] slot_state_i,
   // Interrupt and error.
   output logic irq_o,
   output logic slot_error_pending_o
);

   hpse_db_if dbi ();

   hpse_pkg::hpse_db_vec_t prev_q;
   hpse_pkg::hpse_ev_vec_t ev_q;
   hpse_pkg::hpse_ev_vec_t ev_d;
   hpse_pkg::hpse_ev_vec_t ev_set;
   hpse_pkg::hpse_ev_vec_t ev_clr;
   logic [6:0] msk_q;
   logic m66_q;
   logic [1:0] cap_q;
   logic pf_q;
   hpse_pkg::hpse_ind_t ai_q;
   hpse_pkg::hpse_ind_t pi_q;
   hpse_pkg::hpse_slot_state_t ss_q;
   logic [31:0] rdata_q;
   logic irq_q;
   logic err_q;
   logic hit;
   logic on_now;
   logic on_before;
   logic m66_cap;
   logic [1:0] prs;
   logic [15:0] status;

   // True when a slot state code means powered or enabled.
   function automatic logic is_live(input logic [1:0] code);
      return code == hpse_pkg::HPSE_SS_POWERED || code == hpse_pkg::HPSE_SS_ENABLED;
   endfunction

   // Raw sensor vector: presence pair, latch sensor, button.
   assign dbi.raw = {presence_pin_two_n_i, presence_pin_one_n_i,
                     retention_latch_sensor_i, attention_button_i};

   hpse_debounce u_deb (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .db(dbi)
   );

   // Address decode and current presence.
   assign hit = reg_addr_i == `HPSE_SLOT_OFS;
   assign prs = dbi.clean[`HPSE_DB_PRS_MSB:`HPSE_DB_PRS_LSB];
   assign on_now = is_live(slot_state_i);
   assign on_before = is_live(ss_q);
   assign m66_cap = on_now && !on_before;

   // Previous settled levels, used for edge and change detection.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         prev_q <= `HPSE_DB_RST;
      end else begin
         prev_q <= dbi.clean;
      end
   end

   // Slot state, indicators and power fault sampled from the controller.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ss_q <= hpse_pkg::HPSE_SS_DISABLED;
         ai_q <= hpse_pkg::HPSE_IND_OFF;
         pi_q <= hpse_pkg::HPSE_IND_OFF;
         pf_q <= 1'b0;
         cap_q <= 2'b00;
      end else begin
         ss_q <= hpse_pkg::hpse_slot_state_t'(slot_state_i); // R10
         ai_q <= hpse_pkg::hpse_ind_t'(attention_indicator_state_i); // R7 R8
         pi_q <= hpse_pkg::hpse_ind_t'(power_indicator_state_i); // R9
         pf_q <= power_fault_state_i; // R6
         cap_q <= card_bus_capability_i; // R1
      end
   end

   // 66 MHz capability is latched as the slot enters a powered or enabled state.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         m66_q <= 1'b0;
      end else if (m66_cap) begin
         m66_q <= card_66mhz_capable_i; // R3
      end
   end

   // Event sources; none of them looks at a mask.
   always_comb begin
      ev_set = `HPSE_EV_RST;
      ev_set[`HPSE_EV_CPF] = connected_power_fault_i; // R11 R19
      ev_set[`HPSE_EV_LAT] = dbi.clean[`HPSE_DB_LAT] != prev_q[`HPSE_DB_LAT]; // R12
      ev_set[`HPSE_EV_BTN] = dbi.clean[`HPSE_DB_BTN] && !prev_q[`HPSE_DB_BTN]; // R13
      ev_set[`HPSE_EV_IPF] = isolated_power_fault_i; // R14
      ev_set[`HPSE_EV_PRS] = prs != prev_q[`HPSE_DB_PRS_MSB:`HPSE_DB_PRS_LSB]; // R15
   end

   // Write-one-to-clear; a set in the same cycle wins over the clear.
   always_comb begin
      ev_clr = `HPSE_EV_RST;
      if (reg_wr_i && hit) begin
         ev_clr = reg_wdata_i[`HPSE_EV_MSB:`HPSE_EV_LSB];
      end
      ev_d = (ev_q & ~ev_clr) | ev_set; // R16
   end

   // Event latch register.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ev_q <= `HPSE_EV_RST; // R16
      end else begin
         ev_q <= ev_d;
      end
   end

   // Seven-bit mask field: interrupt masks in the low five bits, error masks above.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         msk_q <= `HPSE_MSK_RST;
      end else if (reg_wr_i && hit) begin
         msk_q <= reg_wdata_i[`HPSE_MSK_MSB:`HPSE_MSK_LSB];
      end
   end

   // Status field as read by software.
   always_comb begin
      status = '0; // R16
      status[`HPSE_ST_CAP_MSB:`HPSE_ST_CAP_LSB] = cap_q; // R1
      if (prs == hpse_pkg::HPSE_PRS_EMPTY) begin
         status[`HPSE_ST_CAP_MSB:`HPSE_ST_CAP_LSB] = `HPSE_CAP_EMPTY; // R1
      end
      status[`HPSE_ST_PRS_MSB:`HPSE_ST_PRS_LSB] = prs; // R2
      status[`HPSE_ST_M66] = m66_q; // R3
      status[`HPSE_ST_LAT] = dbi.clean[`HPSE_DB_LAT]; // R4
      status[`HPSE_ST_BTN] = dbi.clean[`HPSE_DB_BTN]; // R5
      status[`HPSE_ST_FLT] = pf_q; // R6
      status[`HPSE_ST_ATT_MSB:`HPSE_ST_ATT_LSB] = ai_q; // R7
      status[`HPSE_ST_PWR_MSB:`HPSE_ST_PWR_LSB] = pi_q; // R9
      status[`HPSE_ST_SS_MSB:`HPSE_ST_SS_LSB] = ss_q; // R10
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_q <= `HPSE_WORD_RST;
      end else if (reg_rd_i && hit) begin
         rdata_q <= {1'b0, msk_q, 3'b000, ev_q, status}; // R16
      end else begin
         rdata_q <= `HPSE_WORD_RST;
      end
   end

   // Interrupt and error outputs, one cycle behind the latch.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         irq_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         irq_q <= |(ev_q & ~msk_q[`HPSE_IMSK_MSB:0]); // R19
         err_q <= |(ev_q[`HPSE_EV_CPF:`HPSE_EV_LAT]
                    & ~msk_q[`HPSE_SMSK_MSB:`HPSE_SMSK_LSB]); // R18
      end
   end

   assign reg_rdata_o = rdata_q;
   assign irq_o = irq_q;
   assign slot_error_pending_o = err_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // Connected power fault always latches, whatever the mask.
   connected_fault_set_a: // R11
   assert property (connected_power_fault_i |=> ev_q[`HPSE_EV_CPF])
      else $error("connected fault event not latched");

   // Isolated power fault always latches.
   isolated_fault_set_a: // R14
   assert property (isolated_power_fault_i |=> ev_q[`HPSE_EV_IPF])
      else $error("isolated fault event not latched");

   // Latch sensor change in either direction latches.
   latch_change_a: // R12
   assert property ((dbi.clean[`HPSE_DB_LAT] != prev_q[`HPSE_DB_LAT])
                    |=> ev_q[`HPSE_EV_LAT])
      else $error("latch change event missed");

   // Button press sets the event; a release alone does not.
   button_press_a: // R13
   assert property ((!ev_q[`HPSE_EV_BTN] && !ev_clr[`HPSE_EV_BTN]
                     && !(dbi.clean[`HPSE_DB_BTN] && !prev_q[`HPSE_DB_BTN]))
                    |=> !ev_q[`HPSE_EV_BTN])
      else $error("button event set without a press");

   // Presence change latches.
   presence_change_a: // R15
   assert property ((prs != prev_q[`HPSE_DB_PRS_MSB:`HPSE_DB_PRS_LSB])
                    |=> ev_q[`HPSE_EV_PRS])
      else $error("presence change event missed");

   // A latched event holds until a one is written to it.
   event_hold_a: // R16
   assert property (##1 (($past(ev_q) & ~$past(ev_clr) & ~ev_q) == '0))
      else $error("event bit dropped without a clear");

   // Read data carry presence and zero reserved bits one cycle after a read.
   read_word_a: // R2
   assert property ((reg_rd_i && hit)
                    |=> (reg_rdata_o[`HPSE_ST_PRS_MSB:`HPSE_ST_PRS_LSB] == $past(prs))
                    && (reg_rdata_o[`HPSE_RSV_ST_MSB:`HPSE_RSV_ST_LSB] == '0)
                    && (reg_rdata_o[`HPSE_RSV_EV_MSB:`HPSE_RSV_EV_LSB] == '0)
                    && (reg_rdata_o[`HPSE_RSV_TOP] == 1'b0))
      else $error("slot read word wrong");

   // Capability is caught on entry to a live state.
   cap66_latch_a: // R3
   assert property (m66_cap |=> m66_q == $past(card_66mhz_capable_i))
      else $error("66 MHz capability not captured");

   // Error pending follows unmasked error events one cycle later.
   error_pending_a: // R18
   assert property (##1 slot_error_pending_o == $past(|(ev_q[`HPSE_EV_CPF:`HPSE_EV_LAT]
                    & ~msk_q[`HPSE_SMSK_MSB:`HPSE_SMSK_LSB])))
      else $error("error pending wrong");

   // Interrupt follows unmasked events one cycle later.
   irq_level_a: // R19
   assert property (##1 irq_o == $past(|(ev_q & ~msk_q[`HPSE_IMSK_MSB:0])))
      else $error("interrupt level wrong");

   // Capability reads the input of two edges before, while a card is present.
   card_cap_read_a: // R1
   assert property ((reg_rd_i && hit && !$past(sys_rst_i) && prs != hpse_pkg::HPSE_PRS_EMPTY)
                    |=> reg_rdata_o[`HPSE_ST_CAP_MSB:`HPSE_ST_CAP_LSB]
                        == $past(card_bus_capability_i, 2))
      else $error("capability field wrong");

   // Latch sensor bit reads the settled level.
   latch_read_a: // R4
   assert property ((reg_rd_i && hit)
                    |=> reg_rdata_o[`HPSE_ST_LAT] == $past(dbi.clean[`HPSE_DB_LAT]))
      else $error("latch sensor bit wrong");

   // Button bit reads the settled level.
   button_read_a: // R5
   assert property ((reg_rd_i && hit)
                    |=> reg_rdata_o[`HPSE_ST_BTN] == $past(dbi.clean[`HPSE_DB_BTN]))
      else $error("button bit wrong");

   // Fault bit reads the controller fault latch of two edges before.
   fault_read_a: // R6
   assert property ((reg_rd_i && hit && !$past(sys_rst_i))
                    |=> reg_rdata_o[`HPSE_ST_FLT] == $past(power_fault_state_i, 2))
      else $error("power fault bit wrong");

   // Attention indicator code reads back unchanged.
   attention_read_a: // R7 R8
   assert property ((reg_rd_i && hit && !$past(sys_rst_i))
                    |=> reg_rdata_o[`HPSE_ST_ATT_MSB:`HPSE_ST_ATT_LSB] == $past(attention_indicator_state_i, 2))
      else $error("attention indicator field wrong");

   // Power indicator code reads back unchanged.
   power_ind_read_a: // R9
   assert property ((reg_rd_i && hit && !$past(sys_rst_i))
                    |=> reg_rdata_o[`HPSE_ST_PWR_MSB:`HPSE_ST_PWR_LSB] == $past(power_indicator_state_i, 2))
      else $error("power indicator field wrong");

   // Slot state code reads back unchanged.
   slot_state_read_a: // R10
   assert property ((reg_rd_i && hit && !$past(sys_rst_i))
                    |=> reg_rdata_o[`HPSE_ST_SS_MSB:`HPSE_ST_SS_LSB] == $past(slot_state_i, 2))
      else $error("slot state field wrong");

   // Without a read of the slot register the read port shows zero.
   read_idle_a: // R16
   assert property (!(reg_rd_i && hit) |=> reg_rdata_o == `HPSE_WORD_RST)
      else $error("read data outside a read");

   // A one written to an event bit clears it unless the event repeats.
   event_clear_a: // R16
   assert property ((reg_wr_i && hit)
                    |=> (ev_q & $past(reg_wdata_i[`HPSE_EV_MSB:`HPSE_EV_LSB]) & ~$past(ev_set))
                        == '0)
      else $error("event bit not cleared");

   // A settled press always sets the button event.
   button_set_a: // R13
   assert property ((dbi.clean[`HPSE_DB_BTN] && !prev_q[`HPSE_DB_BTN])
                    |=> ev_q[`HPSE_EV_BTN])
      else $error("button press event missed");

   // An unmasked latch change event raises error pending.
   error_rise_a: // R18
   assert property ((ev_q[`HPSE_EV_LAT] && !msk_q[`HPSE_SMSK_LSB]) |=> slot_error_pending_o)
      else $error("error pending not raised");

   // With both error-capable events clear, error pending drops.
   error_drop_a: // R18
   assert property ((!ev_q[`HPSE_EV_CPF] && !ev_q[`HPSE_EV_LAT]) |=> !slot_error_pending_o)
      else $error("error pending not dropped");

   // An unmasked presence event raises the interrupt.
   irq_rise_a: // R19
   assert property ((ev_q[`HPSE_EV_PRS] && !msk_q[`HPSE_EV_PRS]) |=> irq_o)
      else $error("interrupt not raised");

endmodule

// ===== tb/hpse_partner.sv
// Purpose: Stands in for the slot sensors and the slot power controller.
// Assumes: Every level changes just after a rising clock edge.
// Notes: The bench calls the tasks below by hierarchical name.
`timescale 1ns/1ps
module hpse_partner (
   // Clock.
   input wire logic clk_i,
   // Slot sensors.
   output logic btn_o,
   output logic lat_o,
   output logic prs_one_n_o,
   output logic prs_two_n_o,
   output logic [1:0] cap_o,
   output logic m66_o,
   // Power controller.
   output logic flt_o,
   output logic cpf_o,
   output logic ipf_o,
   output logic [1:0] att_o,
   output logic [1:0] pwr_o,
   output logic [1:0] ss_o
);
   // Start as an empty, disabled slot with both indicators off.
   initial begin
      btn_o = 1'b0;
      lat_o = 1'b0;
      prs_one_n_o = 1'b1;
      prs_two_n_o = 1'b1;
      cap_o = 2'b11;
      m66_o = 1'b0;
      flt_o = 1'b0;
      cpf_o = 1'b0;
      ipf_o = 1'b0;
      att_o = 2'b11;
      pwr_o = 2'b11;
      ss_o = 2'b11;
   end

   // Each task moves its lines right after a rising edge.
   task automatic set_btn(input logic v);
      @(posedge clk_i);
      btn_o <= v;
   endtask

   task automatic set_lat(input logic v);
      @(posedge clk_i);
      lat_o <= v;
   endtask

   // Presence pins are low active; a pin pulled low marks the card class.
   task automatic set_prs(input logic two_n, input logic one_n);
      @(posedge clk_i);
      prs_two_n_o <= two_n;
      prs_one_n_o <= one_n;
   endtask

   task automatic set_card(input logic [1:0] cap, input logic m66);
      @(posedge clk_i);
      cap_o <= cap;
      m66_o <= m66;
   endtask

   // One code drives both indicators and the slot state together.
   task automatic set_power(input logic flt, input logic [1:0] code);
      @(posedge clk_i);
      flt_o <= flt;
      att_o <= code;
      pwr_o <= code;
      ss_o <= code;
   endtask

   // A fault detect lasts one cycle, the shortest the controller may give.
   task automatic fault_pulse(input logic c, input logic i);
      @(posedge clk_i);
      cpf_o <= c;
      ipf_o <= i;
      @(posedge clk_i);
      cpf_o <= 1'b0;
      ipf_o <= 1'b0;
   endtask

   // A short button glitch, well under the settle time.
   task automatic bounce_btn(input int n);
      @(posedge clk_i);
      btn_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      btn_o <= 1'b0;
   endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the slot status and event register.
// Assumes: Inputs settle after about 202 cycles; reads answer one cycle later.
// Notes: Sensor and power levels come from the partner model.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
   logic clk_i;
   logic sys_rst_i;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] rdata;
   logic btn, lat, p1n, p2n, m66, flt, cpf, ipf, irq, err;
   logic [1:0] cap, att, pwr, ss;
   logic [31:0] d;
   int fails;
   int cmp_count;
   int cyc;

   // Free-running 200 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   hpse_slot dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
      .attention_button_i(btn), .retention_latch_sensor_i(lat),
      .presence_pin_one_n_i(p1n), .presence_pin_two_n_i(p2n),
      .card_bus_capability_i(cap), .card_66mhz_capable_i(m66),
      .power_fault_state_i(flt), .connected_power_fault_i(cpf),
      .isolated_power_fault_i(ipf), .attention_indicator_state_i(att),
      .power_indicator_state_i(pwr), .slot_state_i(ss), .irq_o(irq),
      .slot_error_pending_o(err));

   hpse_partner part_u (.clk_i(clk_i), .btn_o(btn), .lat_o(lat), .prs_one_n_o(p1n),
      .prs_two_n_o(p2n), .cap_o(cap), .m66_o(m66), .flt_o(flt), .cpf_o(cpf),
      .ipf_o(ipf), .att_o(att), .pwr_o(pwr), .ss_o(ss));

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One-cycle write strobe.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr <= a;
      wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_i);
      reg_wr <= 1'b0;
   endtask

   // One-cycle read strobe; the word is taken in the following cycle.
   task automatic rd_word(input logic [7:0] a);
      @(posedge clk_i);
      addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_i);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Waits whole cycles, then lets the edge updates land.
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Reads until an event bit sets, bounded well past the settle time.
   task automatic poll(input int b);
      int n;
      n = 0;
      rd_word(8'h00);
      while (d[b] !== 1'b1 && n < 150) begin
         rd_word(8'h00);
         n++;
      end
      `CHK(d[b], 1'b1)
   endtask

   // Cuts a hung run short.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end

   // Main sequence.
   initial begin
      sys_rst_i = 1'b1;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      fails = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd_word(8'h00);
      `CHK(d, 32'h7F00_0C3F)
      wr(8'h04, 32'h0000_0000);
      rd_word(8'h04);
      `CHK(d, 32'h0000_0000)
      rd_word(8'h00);
      `CHK(d[30:24], 7'h7F)
      part_u.set_card(2'b11, 1'b1);
      part_u.set_prs(1'b1, 1'b0);
      poll(16);
      `CHK(d[13:10], 4'hE)
      wr(8'h00, 32'h7E00_FFFF);
      idle(2);
      `CHK(irq, 1'b1)
      wr(8'h00, 32'h7E01_0000);
      idle(2);
      rd_word(8'h00);
      `CHK(d[23:16], 8'h00)
      `CHK(irq, 1'b0)
      for (int i = 0; i < 4; i++) begin
         part_u.set_power(i[0], i[1:0]);
         idle(3);
         rd_word(8'h00);
         `CHK(d[6:0], {i[0], i[1:0], i[1:0], i[1:0]})
         `CHK(d[9], i != 0)
      end
      part_u.set_card(2'b11, 1'b0);
      idle(3);
      rd_word(8'h00);
      `CHK(d[9], 1'b1)
      part_u.bounce_btn(50);
      idle(260);
      rd_word(8'h00);
      `CHK(d[20:16], 5'h00)
      part_u.set_btn(1'b1);
      poll(18);
      `CHK(d[20:16], 5'h04)
      `CHK(d[7], 1'b1)
      `CHK(irq, 1'b0)
      wr(8'h00, 32'h7E04_0000);
      part_u.set_btn(1'b0);
      idle(260);
      rd_word(8'h00);
      `CHK(d[7], 1'b0)
      `CHK(d[18], 1'b0)
      part_u.set_lat(1'b1);
      poll(19);
      `CHK(d[8], 1'b1)
      wr(8'h00, 32'h5E00_0000);
      idle(2);
      `CHK(err, 1'b1)
      wr(8'h00, 32'h5E08_0000);
      idle(2);
      `CHK(err, 1'b0)
      part_u.set_lat(1'b0);
      poll(19);
      `CHK(d[8], 1'b0)
      wr(8'h00, 32'h5E08_0000);
      part_u.fault_pulse(1'b1, 1'b0);
      part_u.fault_pulse(1'b0, 1'b1);
      idle(2);
      rd_word(8'h00);
      `CHK(d[20:16], 5'h12)
      `CHK(err, 1'b0)
      `CHK(irq, 1'b0)
      wr(8'h00, 32'h1E00_0000);
      idle(2);
      `CHK(err, 1'b1)
      wr(8'h00, 32'h1E1F_0000);
      idle(2);
      `CHK(err, 1'b0)
      rd_word(8'h00);
      `CHK(d, 32'h1E00_3A7F)
      end_sim();
   end
endmodule
